// [scwc_pkg.sv]
// scwc_pkg: offsets, field positions, reset values and shared types for the
// scsi control two/three register bank.
// assumes a 32-bit apb register bus with 8-bit registers in the low lane, except the parity seed, which reads back 16 bits.
package scwc_pkg;

  // register byte offsets (printed offsets 0x02/0x03 are not word aligned,
  // so they are indices and the byte address is four times the index)
  localparam logic [7:0] SCWC_IDX_CTL_TWO   = 8'h02;
  localparam logic [7:0] SCWC_IDX_CTL_THREE = 8'h03;
  localparam logic [7:0] SCWC_IDX_EVENTS    = 8'h04;
  localparam logic [7:0] SCWC_IDX_PARITY    = 8'h05;
  localparam logic [7:0] SCWC_IDX_PAR_SEED  = 8'h06;

  // control two field positions
  localparam int SCWC_B_DISC_UNEXP = 7;
  localparam int SCWC_B_CHAINED    = 6;
  localparam int SCWC_B_PAR_MODE   = 5;
  localparam int SCWC_B_PAR_HIGH   = 4;
  localparam int SCWC_B_WIDE_SEND  = 3;
  localparam int SCWC_B_GRP_VENDOR = 2;
  localparam int SCWC_B_RELOAD_DIS = 1;
  localparam int SCWC_B_WIDE_RECV  = 0;

  // control three field positions
  localparam int SCWC_B_ULTRA      = 7;
  localparam int SCWC_B_SYNC_LSB   = 4;
  localparam int SCWC_B_WIDE_EN    = 3;
  localparam int SCWC_B_CORE_LSB   = 0;

  // event status bit: unexpected disconnect, as in interrupt status bit 2
  localparam int SCWC_B_UNEXP_DISC = 2;

  localparam logic [7:0] SCWC_RST_CTL_TWO   = 8'h00;
  localparam logic [7:0] SCWC_RST_CTL_THREE = 8'h00;

  // request/ack filter periods in ns
  localparam int SCWC_FILTER_ULTRA_NS = 15;
  localparam int SCWC_CLK_NS          = 10;
  localparam int SCWC_FILTER_ULTRA_CYC =
    (SCWC_FILTER_ULTRA_NS + SCWC_CLK_NS - 1) / SCWC_CLK_NS;

  // divide factor in half steps: code -> 2*factor
  localparam logic [3:0] SCWC_DIV2_CODE0 = 4'h6;
  localparam logic [3:0] SCWC_DIV2_CODE1 = 4'h2;
  localparam logic [3:0] SCWC_DIV2_CODE2 = 4'h3;
  localparam logic [3:0] SCWC_DIV2_CODE3 = 4'h4;
  localparam logic [3:0] SCWC_DIV2_CODE4 = 4'h6;
  localparam logic [3:0] SCWC_DIV2_CODE5 = 4'h8;

  // core transfer events from the scsi sequencer
  typedef struct packed {
    logic initiator;       // core is in initiator mode
    logic bus_free;        // pulse: bus entered bus free phase
    logic sel_done;        // pulse: reselected or selected another device
    logic chain_move;      // pulse: chained block move started
    logic plain_move;      // pulse: ordinary block move started
    logic xfer_start;      // pulse: data transfer starts
    logic xfer_send;       // direction of that transfer, 1 = send
    logic xfer_wide;       // transfer is a wide data phase
    logic xfer_end;        // pulse: transfer ends
    logic xfer_odd;        // it ended on an odd byte
    logic async_tgt_recv;  // pulse: asynchronous target receive starts
    logic grp_vendor;      // group code class of first command byte
    logic cmd_first_byte;  // pulse: first command byte received
    logic grp_standard;    // that byte is a standard group code
  } scwc_evt_t;

  // decoded controls toward the scsi core
  typedef struct packed {
    logic       ultra_filter;   // use the short req/ack filter
    logic       wide_bus;       // data phases use both lanes
    logic [3:0] sync_div2;      // twice the sync divide factor
    logic [3:0] core_div2;      // twice the core divide factor
    logic       div_reserved;   // a reserved code is programmed
    logic       chained;        // chained transfer mode
    logic       hold_send_low;  // send: latched byte goes out as low byte
    logic       hold_recv_high; // receive: residue byte delivered first
    logic       reload_count;   // pulse: reload block move byte count
    logic       unexp_disc;     // pulse: unexpected disconnect
    logic       clear_imm_arb;  // pulse: drop immediate arbitration
  } scwc_ctl_t;

endpackage

// [scwc_regs.sv]
// scwc_regs: scsi control two/three register bank with apb slave.
// assumes core events arrive as single-cycle pulses synchronous to pclk.
// Behaviour
// RULE1: flag unexpected disconnect on bus free, initiator
// RULE2: set disconnect flag on select or reselect
// RULE3: software clears disconnect flag before expected disconnect
// RULE4: chained move sets, plain move clears chained
// RULE5: odd chained end keeps byte for pairing
// RULE6: parity mode shows one byte, accepts seed
// RULE7: high select picks parity word byte
// RULE8: wide send bit reads flag, write clears
// RULE9: held send byte goes out as low
// RULE10: receive or narrow transfer clears wide send
// RULE11: group code flag reloaded on target receive
// RULE12: reload byte count unless reload disabled
// RULE13: wide receive bit reads flag, write clears
// RULE14: partial wide receive holds high byte
// RULE15: send or narrow transfer clears wide receive
// RULE16: ultra forces 15 ns filter
// RULE17: ultra only with 80 MHz clock; the bank does not check the clock, the ultra bit alone sets the filter
// RULE18: sync divide field feeds sync logic
// RULE19: wide enable selects 16-bit data lanes
// RULE20: clearing wide enable clears wide receive
// RULE21: divide codes map to factors, two reserved
// RULE22: software picks core divide from frequency
// RULE23: unexpected disconnect clears immediate arbitration
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module scwc_regs
  import scwc_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [9:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire scwc_pkg::scwc_evt_t    evt,
  input  wire logic [15:0]            parity_word,
  output logic      [15:0]            parity_seed,
  output logic                        parity_seed_load,
  output scwc_pkg::scwc_ctl_t         ctl
);
  import scwc_pkg::*;

  typedef struct packed {
    logic [7:0]  ctl_two;
    logic [7:0]  ctl_three;
    logic        unexp_disc_sticky;
    logic [15:0] seed;
    logic        seed_load;
    logic [31:0] rdata;
    scwc_ctl_t   out;
  } scwc_state_t;

  scwc_state_t st;
  scwc_state_t next_st;

  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] par_view;
  logic [7:0] wdat;

  // apb decode: zero-wait slave, unmapped addresses answer with pslverr
  assign acc    = psel && penable;
  assign wr     = acc && pwrite && pstrb[0];
  assign rd     = acc && !pwrite;
  assign idx    = paddr[9:2];
  assign wdat   = pwdata[7:0];
  assign mapped = (idx >= SCWC_IDX_CTL_TWO) && (idx <= SCWC_IDX_PAR_SEED) &&
                  (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // RULE6 parity view: legacy low byte unless the view mode is on
  // RULE7 high select picks the upper parity byte
  assign par_view = (st.ctl_two[SCWC_B_PAR_MODE] && st.ctl_two[SCWC_B_PAR_HIGH]) ?
                    parity_word[15:8] : parity_word[7:0];

  function automatic logic [3:0] scwc_div2(input logic [2:0] code);
    // RULE21 divide code to twice the factor; reserved codes fall back
    unique case (code)
      3'h0:    scwc_div2 = SCWC_DIV2_CODE0;
      3'h1:    scwc_div2 = SCWC_DIV2_CODE1;
      3'h2:    scwc_div2 = SCWC_DIV2_CODE2;
      3'h3:    scwc_div2 = SCWC_DIV2_CODE3;
      3'h4:    scwc_div2 = SCWC_DIV2_CODE4;
      3'h5:    scwc_div2 = SCWC_DIV2_CODE5;
      default: scwc_div2 = SCWC_DIV2_CODE0;
    endcase
  endfunction

  // next state: software writes first, hardware events after, so a hardware event wins
  always_comb begin
    next_st = st;
    next_st.seed_load = 1'b0;
    next_st.out.reload_count  = 1'b0;
    next_st.out.unexp_disc    = 1'b0;
    next_st.out.clear_imm_arb = 1'b0;

    // software writes; status bits keep their value, write-one clears
    if (wr && idx == SCWC_IDX_CTL_TWO) begin
      next_st.ctl_two[7:4] = wdat[7:4];
      next_st.ctl_two[SCWC_B_RELOAD_DIS] = wdat[SCWC_B_RELOAD_DIS];
      // RULE8 write one clears wide send, nothing to reset afterwards
      if (wdat[SCWC_B_WIDE_SEND]) begin
        next_st.ctl_two[SCWC_B_WIDE_SEND] = 1'b0;
      end
      // RULE13 write one clears wide receive, self-resetting
      if (wdat[SCWC_B_WIDE_RECV]) begin
        next_st.ctl_two[SCWC_B_WIDE_RECV] = 1'b0;
      end
    end
    if (wr && idx == SCWC_IDX_CTL_THREE) begin
      next_st.ctl_three = wdat;
      // RULE20 dropping wide enable discards the residue flag
      if (!wdat[SCWC_B_WIDE_EN]) begin
        next_st.ctl_two[SCWC_B_WIDE_RECV] = 1'b0;
      end
    end
    // event status: write one to clear
    if (wr && idx == SCWC_IDX_EVENTS && wdat[SCWC_B_UNEXP_DISC]) begin
      next_st.unexp_disc_sticky = 1'b0;
    end
    // RULE6 seed only accepted in view mode, into the selected byte
    if (wr && idx == SCWC_IDX_PAR_SEED && st.ctl_two[SCWC_B_PAR_MODE]) begin
      if (st.ctl_two[SCWC_B_PAR_HIGH]) begin
        next_st.seed[15:8] = wdat;
      end else begin
        next_st.seed[7:0] = wdat;
      end
      next_st.seed_load = 1'b1;
    end

    // RULE2 selection sets the disconnect-unexpected bit
    if (evt.sel_done) begin
      next_st.ctl_two[SCWC_B_DISC_UNEXP] = 1'b1;
    end
    // RULE1 bus free while not expected: flag error
    // RULE23 and cancel immediate arbitration instead of arbitrating
    if (evt.bus_free && evt.initiator && st.ctl_two[SCWC_B_DISC_UNEXP]) begin
      next_st.unexp_disc_sticky = 1'b1;
      next_st.out.unexp_disc    = 1'b1;
      next_st.out.clear_imm_arb = 1'b1;
    end
    // RULE4 chained move sets, plain move clears
    if (evt.chain_move) begin
      next_st.ctl_two[SCWC_B_CHAINED] = 1'b1;
    end else if (evt.plain_move) begin
      next_st.ctl_two[SCWC_B_CHAINED] = 1'b0;
    end
    // RULE10 receive or narrow transfer clears wide send
    // RULE15 send or narrow transfer clears wide receive
    if (evt.xfer_start) begin
      if (!evt.xfer_send || !evt.xfer_wide) begin
        next_st.ctl_two[SCWC_B_WIDE_SEND] = 1'b0;
      end
      if (evt.xfer_send || !evt.xfer_wide) begin
        next_st.ctl_two[SCWC_B_WIDE_RECV] = 1'b0;
      end
    end
    // RULE5 odd chained end keeps the byte; RULE14 receive holds high byte
    if (evt.xfer_end && evt.xfer_odd && evt.xfer_wide && st.ctl_three[SCWC_B_WIDE_EN]) begin
      if (evt.xfer_send && st.ctl_two[SCWC_B_CHAINED]) begin
        next_st.ctl_two[SCWC_B_WIDE_SEND] = 1'b1;
      end else if (!evt.xfer_send) begin
        next_st.ctl_two[SCWC_B_WIDE_RECV] = 1'b1;
      end
    end
    // RULE11 group code flag reloaded at asynchronous target receive
    if (evt.async_tgt_recv) begin
      next_st.ctl_two[SCWC_B_GRP_VENDOR] = evt.grp_vendor;
    end
    // RULE12 reload byte count on standard code unless disabled
    if (evt.cmd_first_byte && evt.grp_standard && !st.ctl_two[SCWC_B_RELOAD_DIS]) begin
      next_st.out.reload_count = 1'b1;
    end

    // decoded controls
    // RULE16 ultra forces the short filter
    next_st.out.ultra_filter   = next_st.ctl_three[SCWC_B_ULTRA];
    // RULE19 wide enable opens the upper lane for data phases
    next_st.out.wide_bus       = next_st.ctl_three[SCWC_B_WIDE_EN];
    // RULE18 sync factor feeds the synchronous logic
    next_st.out.sync_div2      = scwc_div2(next_st.ctl_three[6:4]);
    next_st.out.core_div2      = scwc_div2(next_st.ctl_three[2:0]);
    next_st.out.div_reserved   = (next_st.ctl_three[6:5] == 2'h3) ||
                                 (next_st.ctl_three[2:1] == 2'h3);
    next_st.out.chained        = next_st.ctl_two[SCWC_B_CHAINED];
    // RULE9 latched send byte goes out as low byte
    next_st.out.hold_send_low  = next_st.ctl_two[SCWC_B_WIDE_SEND];
    next_st.out.hold_recv_high = next_st.ctl_two[SCWC_B_WIDE_RECV];

    // read data registered at setup, valid in the access cycle
    next_st.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (idx)
        SCWC_IDX_CTL_TWO:   next_st.rdata[7:0] = st.ctl_two;
        SCWC_IDX_CTL_THREE: next_st.rdata[7:0] = st.ctl_three;
        SCWC_IDX_EVENTS:    next_st.rdata[SCWC_B_UNEXP_DISC] = st.unexp_disc_sticky;
        SCWC_IDX_PARITY:    next_st.rdata[7:0] = par_view;
        SCWC_IDX_PAR_SEED:  next_st.rdata[15:0] = st.seed;
        default:            next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = rd ? st.rdata : 32'h0000_0000;
  assign ctl              = st.out;
  assign parity_seed      = st.seed;
  assign parity_seed_load = st.seed_load;

  // checks
  a_unexp_disc_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    evt.bus_free && evt.initiator && st.ctl_two[SCWC_B_DISC_UNEXP]
      |=> st.unexp_disc_sticky && ctl.unexp_disc)
    else $error("unexpected disconnect not flagged");
  a_sel_sets_du: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    evt.sel_done |=> st.ctl_two[SCWC_B_DISC_UNEXP])
    else $error("selection did not set disconnect flag");
  a_chain_mode: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    evt.chain_move |=> ctl.chained)
    else $error("chained move did not set chained mode");
  a_wide_send_clr: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    wr && idx == SCWC_IDX_CTL_TWO && wdat[SCWC_B_WIDE_SEND] && !evt.xfer_end
      |=> !st.ctl_two[SCWC_B_WIDE_SEND] ##1 !st.ctl_two[SCWC_B_WIDE_SEND] || $past(evt.xfer_end))
    else $error("wide send flag not cleared");
  a_recv_clr_ws: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    evt.xfer_start && !evt.xfer_send && !evt.xfer_end |=> !ctl.hold_send_low)
    else $error("receive did not clear wide send");
  a_grp_reload: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    evt.async_tgt_recv |=> st.ctl_two[SCWC_B_GRP_VENDOR] == $past(evt.grp_vendor))
    else $error("group code flag not reloaded");
  a_count_reload: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    evt.cmd_first_byte |=> ctl.reload_count ==
      $past(evt.grp_standard && !st.ctl_two[SCWC_B_RELOAD_DIS]))
    else $error("byte count reload wrong");
  a_send_clr_wr: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    evt.xfer_start && evt.xfer_send && !evt.xfer_end |=> !ctl.hold_recv_high)
    else $error("send did not clear wide receive");
  a_ultra_filter: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    ctl.ultra_filter == st.ctl_three[SCWC_B_ULTRA])
    else $error("ultra filter not following enable");
  a_wide_off_clr: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    wr && idx == SCWC_IDX_CTL_THREE && !wdat[SCWC_B_WIDE_EN]
      |=> !st.ctl_two[SCWC_B_WIDE_RECV] && !ctl.wide_bus)
    else $error("wide enable clear left residue flag");
  a_div_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    st.ctl_three[2:0] == 3'h5 |-> ctl.core_div2 == 4'h8)
    else $error("core divide by four wrong");

  // odd end of a wide data phase while the wide lanes are open; the
  // direction and chained mode then decide which flag takes the byte
  sequence s_odd_wide_end;
    evt.xfer_end && evt.xfer_odd && evt.xfer_wide && ctl.wide_bus;
  endsequence
  sequence s_chained_send;
    evt.xfer_send && ctl.chained;
  endsequence

  a_odd_send_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    s_odd_wide_end ##0 s_chained_send |=> ctl.hold_send_low)
    else $error("odd chained send did not keep its byte");
  a_odd_recv_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    s_odd_wide_end ##0 !evt.xfer_send |=> ctl.hold_recv_high)
    else $error("partial wide receive did not hold high byte");
  a_chain_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    evt.plain_move && !evt.chain_move |=> !ctl.chained)
    else $error("plain move did not clear chained mode");
  a_seed_accept: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    wr && idx == SCWC_IDX_PAR_SEED && st.ctl_two[SCWC_B_PAR_MODE] |=> parity_seed_load)
    else $error("seed write in view mode not loaded");
  a_par_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    st.ctl_two[SCWC_B_PAR_MODE] && st.ctl_two[SCWC_B_PAR_HIGH]
      |-> par_view == parity_word[15:8])
    else $error("parity view not showing high byte");
  a_send_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    ctl.hold_send_low == st.ctl_two[SCWC_B_WIDE_SEND])
    else $error("held send byte not following wide send flag");
  a_wide_recv_clr: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    wr && idx == SCWC_IDX_CTL_TWO && wdat[SCWC_B_WIDE_RECV] && !evt.xfer_end
      |=> !ctl.hold_recv_high)
    else $error("wide receive flag not cleared by write");
  a_sync_div: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    st.ctl_three[6:4] == 3'h5 |-> ctl.sync_div2 == 4'h8)
    else $error("sync divide by four wrong");
  a_wide_lane: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    ctl.wide_bus == st.ctl_three[SCWC_B_WIDE_EN])
    else $error("wide bus not following wide enable");
  a_imm_arb: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    ctl.unexp_disc |-> ctl.clear_imm_arb)
    else $error("unexpected disconnect kept immediate arbitration");

endmodule
`default_nettype wire

// [scwc_core_model.sv]
// scwc_core_model: stand-in for the scsi sequencer that drives core events.
// assumes the bench changes req and req_vld just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none
module scwc_core_model (
  input  wire logic [13:0]         req,
  input  wire logic                req_vld,
  input  wire logic [15:0]         pw,
  output scwc_pkg::scwc_evt_t      evt,
  output logic      [15:0]         parity_word
);
  import scwc_pkg::*;

  // pulse fields of the event record; levels keep their last value
  localparam logic [13:0] PULSES = 14'h1F2A;

  // pulses live only while req_vld is high, so each lasts one cycle
  assign evt = scwc_evt_t'(req_vld ? req : (req & ~PULSES));
  // parity word is a plain level from the core
  assign parity_word = pw;
endmodule
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for the scsi control two/three bank.
// assumes a zero-wait apb slave and events that act one edge later.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  import scwc_pkg::*;
  localparam logic [13:0] INI = 14'h2000, BFR = 14'h1000, SEL = 14'h0800;
  localparam logic [13:0] CHN = 14'h0400, PLN = 14'h0200, XST = 14'h0100;
  localparam logic [13:0] SND = 14'h0080, WID = 14'h0040, XEN = 14'h0020;
  localparam logic [13:0] ODD = 14'h0010, ATR = 14'h0008, GVU = 14'h0004;
  localparam logic [13:0] CFB = 14'h0002, GST = 14'h0001;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        req_vld, seed_load, slv;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, rnd;
  logic [3:0]  pstrb;
  logic [13:0] req;
  logic [15:0] pw, parity_word, seed, es;
  logic [7:0]  c3;
  logic [2:0]  sc;
  scwc_evt_t   evt;
  scwc_ctl_t   ctl;
  int          error_cnt, cmp_count, cyc;

  scwc_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .parity_word(parity_word),
    .parity_seed(seed), .parity_seed_load(seed_load), .ctl(ctl));
  scwc_core_model core (.req(req), .req_vld(req_vld), .pw(pw), .evt(evt),
    .parity_word(parity_word));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // twice the divide factor, as the core sees it
  function automatic logic [3:0] div2(input logic [2:0] c);
    case (c)
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      3'h3: return 4'h4;
      3'h5: return 4'h8;
      default: return 4'h6;
    endcase
  endfunction

  task automatic stop_test;
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {rnd[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one core event; pulse outputs are looked at in the cycle they stand
  task automatic ev(input logic [13:0] v);
    @(posedge pclk);
    req <= v;
    req_vld <= 1'b1;
    @(posedge pclk);
    req_vld <= 1'b0;
    #1;
  endtask

  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hF; req = '0; req_vld = 1'b0; pw = '0; rnd = 32'd94841;
    es = '0; presetn = 1'b0; error_cnt = 0; cmp_count = 0; cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[7:0], SCWC_RST_CTL_TWO)
    apb(1'b0, SCWC_IDX_CTL_THREE, 8'h00);
    `CHK(rdv[7:0], SCWC_RST_CTL_THREE)
    // every divide code; sync code random among the legal ones
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      sc = 3'(rnd % 6);
      // ultra only with the divide by four band
      c3 = {i == 5, sc, rnd[3], i[2:0]};
      apb(1'b1, SCWC_IDX_CTL_THREE, c3);
      apb(1'b0, SCWC_IDX_CTL_THREE, 8'h00);
      `CHK(rdv[7:0], c3)
      `CHK(ctl.core_div2, div2(i[2:0]))
      `CHK(ctl.div_reserved, i >= 6)
      `CHK(ctl.sync_div2, div2(sc))
      `CHK(ctl.ultra_filter, i == 5)
      `CHK(ctl.wide_bus, rnd[3])
    end
    apb(1'b1, SCWC_IDX_CTL_THREE, 8'hDD);
    // selection arms the disconnect flag; bus free then reports it
    ev(SEL);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[7], 1'b1)
    ev(INI | BFR);
    `CHK(ctl.unexp_disc, 1'b1)
    `CHK(ctl.clear_imm_arb, 1'b1)
    apb(1'b0, SCWC_IDX_EVENTS, 8'h00);
    `CHK(rdv[SCWC_B_UNEXP_DISC], 1'b1)
    apb(1'b1, SCWC_IDX_EVENTS, 8'h04);
    apb(1'b0, SCWC_IDX_EVENTS, 8'h00);
    `CHK(rdv[SCWC_B_UNEXP_DISC], 1'b0)
    // flag cleared by software before an expected disconnect
    apb(1'b1, SCWC_IDX_CTL_TWO, 8'h00);
    ev(INI | BFR);
    `CHK(ctl.unexp_disc, 1'b0)
    `CHK(ctl.clear_imm_arb, 1'b0)
    ev(SEL);
    ev(BFR);
    `CHK(ctl.unexp_disc, 1'b0)
    // chained mode follows the kind of block move
    ev(CHN);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[6], 1'b1)
    ev(PLN);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[6], 1'b0)
    ev(CHN);
    // odd wide send keeps a byte; write, receive or narrow clears it
    for (int k = 0; k < 3; k++) begin
      ev(SND | WID | XST);
      ev(SND | WID | XEN | ODD);
      apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
      `CHK(rdv[3], 1'b1)
      `CHK(ctl.hold_send_low, 1'b1)
      if (k == 0) apb(1'b1, SCWC_IDX_CTL_TWO, 8'h48);
      else ev(k == 1 ? (WID | XST) : (SND | XST));
      apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
      `CHK(rdv[3], 1'b0)
    end
    // odd wide receive holds the high byte; four ways to drop it
    for (int k = 0; k < 4; k++) begin
      ev(WID | XST);
      ev(WID | XEN | ODD);
      apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
      `CHK(rdv[0], 1'b1)
      `CHK(ctl.hold_recv_high, 1'b1)
      if (k == 0) apb(1'b1, SCWC_IDX_CTL_TWO, 8'h41);
      else if (k == 3) apb(1'b1, SCWC_IDX_CTL_THREE, 8'h55);
      else ev(k == 1 ? (SND | WID | XST) : XST);
      apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
      `CHK(rdv[0], 1'b0)
    end
    // group code class reloads on target receive and is read only
    ev(ATR | GVU);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[2], 1'b1)
    apb(1'b1, SCWC_IDX_CTL_TWO, 8'h00);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[2], 1'b1)
    ev(ATR);
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[2], 1'b0)
    // byte count reload on a standard first byte, unless disabled
    ev(CFB | GST);
    `CHK(ctl.reload_count, 1'b1)
    ev(CFB);
    `CHK(ctl.reload_count, 1'b0)
    apb(1'b1, SCWC_IDX_CTL_TWO, 8'h02);
    ev(CFB | GST);
    `CHK(ctl.reload_count, 1'b0)
    // parity view shows the chosen byte; seed lands in that byte
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      pw <= rnd[15:0];
      apb(1'b1, SCWC_IDX_CTL_TWO, {2'b00, 1'b1, k[0], 4'h0});
      apb(1'b0, SCWC_IDX_PARITY, 8'h00);
      `CHK(rdv[7:0], k[0] ? pw[15:8] : pw[7:0])
      apb(1'b1, SCWC_IDX_PAR_SEED, rnd[23:16]);
      if (k[0]) es[15:8] = rnd[23:16];
      else es[7:0] = rnd[23:16];
      #1;
      `CHK(seed, es)
      `CHK(seed_load, 1'b1)
    end
    apb(1'b1, SCWC_IDX_CTL_TWO, 8'h00);
    apb(1'b1, SCWC_IDX_PAR_SEED, 8'hA5);
    apb(1'b0, SCWC_IDX_PAR_SEED, 8'h00);
    `CHK(rdv[15:0], es)
    // unmapped places answer with an error, read zero, change nothing
    foreach (c3[b]) begin
      apb(1'b1, {b[0], 7'h07}, 8'hFF);
      apb(1'b0, {b[0], 7'h07}, 8'h00);
      `CHK(slv, 1'b1)
      `CHK(rdv, 32'h00000000)
    end
    // a write without the low byte lane enabled leaves the register alone
    pstrb <= 4'hE;
    apb(1'b1, SCWC_IDX_CTL_THREE, 8'hFF);
    pstrb <= 4'hF;
    apb(1'b0, SCWC_IDX_CTL_THREE, 8'h00);
    `CHK(rdv[7:0], 8'h55)
    apb(1'b0, SCWC_IDX_CTL_TWO, 8'h00);
    `CHK(rdv[7:0], 8'h00)
    stop_test();
  end
endmodule
`default_nettype wire
